// [rtl/atw_cfg.svh]
// Offsets, field positions and reset values of the converter control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef ATW_CFG_SVH
`define ATW_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ATW_OFS_RESULT0 8'h30
`define ATW_OFS_TRIG_EN 8'h70
`define ATW_OFS_TRIG_SRC 8'h74
`define ATW_OFS_WDG_CTRL 8'h78
`define ATW_OFS_WDG_THR 8'h7c
`define ATW_OFS_IRQ_EN 8'h80
`define ATW_OFS_IRQ_RAW 8'h84
`define ATW_OFS_IRQ_MSK 8'h88
`define ATW_OFS_IRQ_CLR 8'h8c
`define ATW_RESULT_LAST 8'h4c

// ****************************************
// Field positions
// ****************************************
`define ATW_VALID_BIT 31
`define ATW_TE_SOFT 0
`define ATW_TE_LINE 1
`define ATW_TE_GPMC 2
`define ATW_TE_BPWM 3
`define ATW_TS_START 0
`define ATW_TS_LINE_LO 8
`define ATW_TS_GPMC_TSEL_LO 16
`define ATW_TS_BPWM_TSEL_B0 19
`define ATW_TS_BPWM_TSEL_HI_LO 22
`define ATW_TS_GPMC_EVT_LO 24
`define ATW_TS_BPWM_EVT_LO 27
`define ATW_WC_LOW_EN 0
`define ATW_WC_UP_EN 1
`define ATW_WC_ALL 2
`define ATW_WC_SEL_LO 8
`define ATW_WC_LCH_LO 16
`define ATW_WC_UCH_LO 24
`define ATW_TH_LOW_LO 0
`define ATW_TH_UP_LO 16
`define ATW_IRQ_SINGLE 0
`define ATW_IRQ_SUBGRP 1
`define ATW_IRQ_CYCLE 2
`define ATW_IRQ_LOWER 16
`define ATW_IRQ_UPPER 17
`define ATW_IRQ_OVWR 24

// ****************************************
// Masks and reset values
// ****************************************
`define ATW_TE_MASK 32'h0000000f
`define ATW_TS_MASK 32'h3fcf0f01
`define ATW_WC_RW_MASK 32'h00000f07
`define ATW_TH_MASK 32'h0fff0fff
`define ATW_IRQ_MASK 32'h01030007
`define ATW_RESET_WORD 32'h00000000
`define ATW_EVT_MAX 3'h4
`define ATW_CH_MAX 4'hb
`define ATW_TSEL_MC 3'h0
`define ATW_TSEL_GP 3'h2
`define ATW_BTSEL_MAX 3'h3

`endif

// [rtl/atw_pkg.sv]
// Types shared by the converter control block.
// Assumes atw_cfg.svh on the include path.
`include "atw_cfg.svh"

package atw_pkg;

  // Result delivered by the conversion core
  typedef struct packed {
    logic [2:0] seq;
    logic [3:0] chan;
    logic [15:0] value;
  } atw_result_s;

  // End-of-conversion events from the core
  typedef struct packed {
    logic cycle;
    logic subgroup;
    logic single;
  } atw_eoc_s;

  // Timer trigger sources, one per timer
  typedef struct packed {
    logic [4:0] mc;
    logic [4:0] gp;
    logic [4:0] bt0;
    logic [4:0] bt1;
    logic [4:0] pw0;
    logic [4:0] pw1;
  } atw_timer_ev_s;

  // Bus slave states
  typedef enum logic [1:0] {
    ATW_BUS_IDLE = 2'b00,
    ATW_BUS_ACK = 2'b01
  } atw_bus_e;

endpackage

// [rtl/atw_top.sv]
// Converter trigger, watchdog and interrupt register block.
// Assumes an Avalon-MM master on clk_i; trigger pins are asynchronous.
`include "atw_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module atw_top #(
  parameter int NUM_RESULTS = 8,
  parameter int NUM_LINES = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_LINES-1:0] line_event_i,
  input wire atw_pkg::atw_timer_ev_s timer_event_i,
  input wire logic result_strobe_i,
  input wire atw_pkg::atw_result_s result_i,
  input wire atw_pkg::atw_eoc_s eoc_i,
  output logic conv_start_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] trig_en_reg;
  logic [31:0] trig_src_reg;
  logic [31:0] wdg_ctrl_reg;
  logic [31:0] wdg_thr_reg;
  logic [31:0] irq_en_reg;
  logic [31:0] irq_raw_reg;
  logic [15:0] result_value [NUM_RESULTS];
  logic [NUM_RESULTS-1:0] result_valid_flag;
  logic [3:0] upper_hit_channel;
  logic [3:0] lower_hit_channel;
  atw_pkg::atw_bus_e bus_reg;
  logic [NUM_LINES-1:0] line_meta_reg;
  logic [NUM_LINES-1:0] line_sync_reg;
  atw_pkg::atw_timer_ev_s tmr_meta_reg;
  atw_pkg::atw_timer_ev_s tmr_sync_reg;

  // Write data merged with byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pick one of five event lines by the 3-bit event code
  function automatic logic pick_event(input logic [4:0] ev,
    input logic [2:0] code);
    logic r;
    r = 1'b0;
    if (code <= `ATW_EVT_MAX) begin
      r = ev[code];
    end
    return r;
  endfunction

  // Channel codes above eleven are reserved and never count as a hit
  function automatic logic chan_ok(input logic [3:0] ch);
    logic r;
    r = 1'b0;
    if (ch <= `ATW_CH_MAX) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  logic wr_hit;
  logic rd_hit;
  logic bus_ack;
  logic in_result;
  logic [2:0] res_idx;
  // Reads are captured when taken so the data stands in the ack cycle;
  // writes land at the ack edge, the one edge the master commits at
  assign bus_ack = bus_reg == atw_pkg::ATW_BUS_ACK;
  assign wr_hit = avs_write_i && bus_ack;
  assign rd_hit = avs_read_i && bus_reg == atw_pkg::ATW_BUS_IDLE;
  assign in_result = avs_address_i >= `ATW_OFS_RESULT0 &&
    avs_address_i <= `ATW_RESULT_LAST;
  assign res_idx = 3'((avs_address_i - `ATW_OFS_RESULT0) >> 2);

  // One wait cycle per access, then acknowledge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_reg <= atw_pkg::ATW_BUS_IDLE;
    end else begin
      case (bus_reg)
        atw_pkg::ATW_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_reg <= atw_pkg::ATW_BUS_ACK;
          end
        end
        atw_pkg::ATW_BUS_ACK: bus_reg <= atw_pkg::ATW_BUS_IDLE;
        default: bus_reg <= atw_pkg::ATW_BUS_IDLE;
      endcase
    end
  end

  // Waitrequest high except in the acknowledge cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_reg == atw_pkg::ATW_BUS_IDLE &&
        (avs_read_i || avs_write_i));
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Writable control words; reserved bits are masked off
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_en_reg <= `ATW_RESET_WORD;
      wdg_ctrl_reg <= `ATW_RESET_WORD;
      wdg_thr_reg <= `ATW_RESET_WORD;
      irq_en_reg <= `ATW_RESET_WORD;
    end else if (wr_hit) begin
      case (avs_address_i)
        `ATW_OFS_TRIG_EN: trig_en_reg <= merge_be(trig_en_reg,
          avs_writedata_i, avs_byteenable_i) & `ATW_TE_MASK;
        `ATW_OFS_WDG_CTRL: wdg_ctrl_reg <= merge_be(wdg_ctrl_reg,
          avs_writedata_i, avs_byteenable_i) & `ATW_WC_RW_MASK;
        `ATW_OFS_WDG_THR: wdg_thr_reg <= merge_be(wdg_thr_reg,
          avs_writedata_i, avs_byteenable_i) & `ATW_TH_MASK;
        `ATW_OFS_IRQ_EN: irq_en_reg <= merge_be(irq_en_reg,
          avs_writedata_i, avs_byteenable_i) & `ATW_IRQ_MASK;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Trigger path
  // ****************************************
  // Two-stage synchronisers for pin and timer events
  // Only the second stage feeds logic; the first may be metastable
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_meta_reg <= '0;
      line_sync_reg <= '0;
      tmr_meta_reg <= '0;
      tmr_sync_reg <= '0;
    end else begin
      line_meta_reg <= line_event_i;
      line_sync_reg <= line_meta_reg;
      tmr_meta_reg <= timer_event_i;
      tmr_sync_reg <= tmr_meta_reg;
    end
  end

  logic [3:0] line_sel;
  logic [2:0] gpmc_tsel;
  logic [2:0] bpwm_tsel;
  logic [2:0] gpmc_esel;
  logic [2:0] bpwm_esel;
  logic line_start;
  logic gpmc_start;
  logic bpwm_start;
  logic soft_start;
  logic [4:0] gpmc_src;
  logic [4:0] bpwm_src;
  assign line_sel = trig_src_reg[`ATW_TS_LINE_LO +: 4];
  assign gpmc_tsel = trig_src_reg[`ATW_TS_GPMC_TSEL_LO +: 3];
  assign bpwm_tsel = {trig_src_reg[`ATW_TS_BPWM_TSEL_HI_LO +: 2],
    trig_src_reg[`ATW_TS_BPWM_TSEL_B0]};
  assign gpmc_esel = trig_src_reg[`ATW_TS_GPMC_EVT_LO +: 3];
  assign bpwm_esel = trig_src_reg[`ATW_TS_BPWM_EVT_LO +: 3];

  // Timer choice; reserved codes select nothing
  always_comb begin
    gpmc_src = 5'h0;
    bpwm_src = 5'h0;
    case (gpmc_tsel)
      `ATW_TSEL_MC: gpmc_src = tmr_sync_reg.mc;
      `ATW_TSEL_GP: gpmc_src = tmr_sync_reg.gp;
      default: gpmc_src = 5'h0;
    endcase
    case (bpwm_tsel)
      3'h0: bpwm_src = tmr_sync_reg.bt0;
      3'h1: bpwm_src = tmr_sync_reg.bt1;
      3'h2: bpwm_src = tmr_sync_reg.pw0;
      3'h3: bpwm_src = tmr_sync_reg.pw1;
      default: bpwm_src = 5'h0;
    endcase
  end

  // Edge is set by the line controller; this takes the event level
  assign line_start = trig_en_reg[`ATW_TE_LINE] &&
    line_sync_reg[line_sel];
  assign gpmc_start = trig_en_reg[`ATW_TE_GPMC] &&
    pick_event(gpmc_src, gpmc_esel);
  assign bpwm_start = trig_en_reg[`ATW_TE_BPWM] &&
    pick_event(bpwm_src, bpwm_esel);
  assign soft_start = trig_en_reg[`ATW_TE_SOFT] &&
    trig_src_reg[`ATW_TS_START];

  // Start pulse towards the conversion core
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= soft_start || line_start || gpmc_start || bpwm_start;
    end
  end

  // Source select; start bit self-clears once the start is issued
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_src_reg <= `ATW_RESET_WORD;
    end else if (wr_hit && avs_address_i == `ATW_OFS_TRIG_SRC) begin
      trig_src_reg <= merge_be(trig_src_reg, avs_writedata_i,
        avs_byteenable_i) & `ATW_TS_MASK;
    end else if (soft_start) begin
      trig_src_reg[`ATW_TS_START] <= 1'b0;
    end
  end

  // ****************************************
  // Results and watchdog
  // ****************************************
  logic watched;
  logic hit_up;
  logic hit_low;
  logic overwrite;
  assign watched = wdg_ctrl_reg[`ATW_WC_ALL] ||
    result_i.chan == wdg_ctrl_reg[`ATW_WC_SEL_LO +: 4];
  assign hit_up = result_strobe_i && watched &&
    wdg_ctrl_reg[`ATW_WC_UP_EN] && chan_ok(result_i.chan) &&
    result_i.value[11:0] > wdg_thr_reg[`ATW_TH_UP_LO +: 12];
  assign hit_low = result_strobe_i && watched &&
    wdg_ctrl_reg[`ATW_WC_LOW_EN] && chan_ok(result_i.chan) &&
    result_i.value[11:0] < wdg_thr_reg[`ATW_TH_LOW_LO +: 12];
  assign overwrite = result_strobe_i &&
    result_valid_flag[result_i.seq];

  // Store results; a read clears valid, a new result wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_valid_flag <= '0;
      for (int i = 0; i < NUM_RESULTS; i++) begin
        result_value[i] <= 16'h0;
      end
    end else begin
      if (rd_hit && in_result) begin
        result_valid_flag[res_idx] <= 1'b0;
      end
      if (result_strobe_i) begin
        result_value[result_i.seq] <= result_i.value;
        result_valid_flag[result_i.seq] <= 1'b1;
      end
    end
  end

  // Hit channel fields, updated with the result write
  // Fields hold their last hit; a result without a hit leaves them alone
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upper_hit_channel <= 4'h0;
      lower_hit_channel <= 4'h0;
    end else begin
      if (hit_up) begin
        upper_hit_channel <= result_i.chan;
      end
      if (hit_low) begin
        lower_hit_channel <= result_i.chan;
      end
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [31:0] ev_set;
  logic [31:0] ev_clr;
  always_comb begin
    ev_set = 32'h0;
    ev_set[`ATW_IRQ_OVWR] = overwrite;
    ev_set[`ATW_IRQ_UPPER] = hit_up;
    ev_set[`ATW_IRQ_LOWER] = hit_low;
    ev_set[`ATW_IRQ_CYCLE] = eoc_i.cycle;
    ev_set[`ATW_IRQ_SUBGRP] = eoc_i.subgroup;
    ev_set[`ATW_IRQ_SINGLE] = eoc_i.single;
    ev_clr = 32'h0;
    if (wr_hit && avs_address_i == `ATW_OFS_IRQ_CLR) begin
      ev_clr = merge_be(32'h0, avs_writedata_i, avs_byteenable_i);
    end
  end

  // Raw status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_raw_reg <= `ATW_RESET_WORD;
    end else begin
      irq_raw_reg <= ((irq_raw_reg & ~ev_clr) | ev_set) &
        `ATW_IRQ_MASK;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured at the taking edge, held until the next read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= `ATW_RESET_WORD;
    end else if (rd_hit) begin
      if (in_result) begin
        avs_readdata_o <= {result_valid_flag[res_idx], 15'h0,
          result_value[res_idx]};
      end else begin
        case (avs_address_i)
          `ATW_OFS_TRIG_EN: avs_readdata_o <= trig_en_reg;
          `ATW_OFS_TRIG_SRC: avs_readdata_o <= trig_src_reg;
          `ATW_OFS_WDG_CTRL: avs_readdata_o <= {4'h0, upper_hit_channel,
            4'h0, lower_hit_channel, wdg_ctrl_reg[15:0]};
          `ATW_OFS_WDG_THR: avs_readdata_o <= wdg_thr_reg;
          `ATW_OFS_IRQ_EN: avs_readdata_o <= irq_en_reg;
          `ATW_OFS_IRQ_RAW: avs_readdata_o <= irq_raw_reg;
          `ATW_OFS_IRQ_MSK: avs_readdata_o <=
            irq_raw_reg & irq_en_reg;
          default: avs_readdata_o <= `ATW_RESET_WORD;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [tb/atw_core_model.sv]
// Stand-in for the conversion core: one result per start.
// Assumes the bench holds next_i and lat_i steady across a start.
`timescale 1ns/1ns
`default_nettype none
module atw_core_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [1:0] lat_i,
  input wire atw_pkg::atw_result_s next_i,
  output logic strobe_o,
  output atw_pkg::atw_result_s result_o,
  output atw_pkg::atw_eoc_s eoc_o
);
  logic busy_reg;
  logic start_d_reg;
  logic [1:0] cnt_reg;
  // ************************************************
  // Start capture, latency count and result pulse
  // ************************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_reg <= 1'b0;
      start_d_reg <= 1'b0;
      cnt_reg <= 2'h0;
      strobe_o <= 1'b0;
    end else begin
      start_d_reg <= start_i;
      strobe_o <= 1'b0;
      if (!busy_reg && start_i && !start_d_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat_i;
      end else if (busy_reg && cnt_reg == 2'h0) begin
        busy_reg <= 1'b0;
        strobe_o <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
  // Result lines toggle away from the value outside the pulse
  assign result_o = strobe_o ? next_i : ~next_i;
  assign eoc_o = {3{strobe_o}};
endmodule
`default_nettype wire

// [tb/atw_monitor.sv]
// Bus and start checks for the converter control block.
// Assumes binding onto atw_top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module atw_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic conv_start_o
);
  logic [3:0] te_reg;
  logic rd_ack;
  logic wr_ack;
  logic [7:0] a;
  assign rd_ack = avs_read_i && !avs_waitrequest_o;
  assign wr_ack = avs_write_i && !avs_waitrequest_o;
  assign a = avs_address_i;
  // Shadow of the trigger enables, updated at each write ack to 8'h70
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      te_reg <= 4'h0;
    end else if (wr_ack && a == 8'h70) begin
      te_reg <= avs_writedata_i[3:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ************************************************
  // Assertions
  // ************************************************
  chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_ack_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i
    || avs_write_i)) else $error("ack without a pending request");
  chk_soft_start: assert property (
    wr_ack && a == 8'h74 && avs_writedata_i[0] && te_reg[0]
    |-> ##[1:2] conv_start_o) else $error("soft start not issued");
  chk_no_start: assert property (
    te_reg == 4'h0 && $past(te_reg) == 4'h0 |-> !conv_start_o)
    else $error("start while all triggers disabled");
  chk_clr_zero: assert property (
    rd_ack && a == 8'h8c |-> avs_readdata_o == 32'h0)
    else $error("clear register reads nonzero");
  chk_unmapped_zero: assert property (
    rd_ack && (a == 8'h00 || a == 8'h90) |-> avs_readdata_o == 32'h0)
    else $error("unmapped address reads nonzero");
  chk_irq_rsvd: assert property (
    rd_ack && a inside {8'h80, 8'h84, 8'h88}
    |-> (avs_readdata_o & 32'hfefcfff8) == 32'h0)
    else $error("interrupt register reserved bits set");
  chk_wdg_fields: assert property (
    rd_ack && a == 8'h78 |-> (avs_readdata_o & 32'hf0f0f0f8) == 32'h0
    && avs_readdata_o[27:24] <= 4'hb && avs_readdata_o[19:16] <= 4'hb)
    else $error("watchdog control field out of range");
  chk_thr_rsvd: assert property (
    rd_ack && a == 8'h7c |-> (avs_readdata_o & 32'hf000f000) == 32'h0)
    else $error("threshold reserved bits set");
  chk_result_rsvd: assert property (
    rd_ack && a >= 8'h30 && a <= 8'h4c |-> avs_readdata_o[30:16] == 15'h0)
    else $error("result reserved bits set");
  // Main scenarios reached
  cov_hit: cover property (rd_ack && a == 8'h78 && avs_readdata_o[27:24] != 0);
  cov_start: cover property (conv_start_o);
  cov_clear: cover property (wr_ack && a == 8'h8c);
endmodule
bind atw_top atw_monitor u_mon (.clk_i, .nrst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
  .avs_waitrequest_o, .conv_start_o);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the converter trigger and watchdog block.
// Assumes atw_top, atw_core_model and atw_monitor compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [15:0] line = 16'h0;
  logic [29:0] tev = 30'h0;
  logic strobe;
  logic start;
  logic start_d = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [31:0] d;
  atw_pkg::atw_result_s res;
  atw_pkg::atw_result_s nxt = '0;
  atw_pkg::atw_eoc_s eoc;
  logic [31:0] expq[$];
  logic [7:0] ofs[5] = '{8'h70, 8'h74, 8'h78, 8'h7c, 8'h80};
  logic [31:0] msk[5] = '{32'hf, 32'h3fcf0f00, 32'hf07, 32'hfff0fff,
    32'h1030007};
  int err_count = 0;
  int num_checks = 0;
  int starts = 0;
  int nres = 0;
  integer seed = 32'hd745;
  atw_top u_dut (.clk_i, .nrst_i, .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .line_event_i(line), .timer_event_i(tev), .result_strobe_i(strobe),
    .result_i(res), .eoc_i(eoc), .conv_start_o(start));
  atw_core_model u_core (.clk_i, .nrst_i, .start_i(start), .lat_i(lat),
    .next_i(nxt), .strobe_o(strobe), .result_o(res), .eoc_o(eoc));
  // Clock, 20 ns period
  always #10 clk_i = ~clk_i;
  // ************************************************
  // Tasks
  // ************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= v;
    @(posedge clk_i);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) err_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic conv(input logic [2:0] s, input logic [3:0] c,
    input logic [15:0] v);
    int n;
    n = nres;
    nxt <= '{seq: s, chan: c, value: v};
    lat <= 2'($random(seed));
    bus(1'b1, 8'h74, 32'h1);
    repeat (20) if (nres == n) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic [15:0] l, input logic [29:0] t,
    input int e);
    int n;
    n = starts;
    @(posedge clk_i);
    line <= l;
    tev <= t;
    repeat (6) @(posedge clk_i);
    line <= 16'h0;
    tev <= 30'h0;
    repeat (8) @(posedge clk_i);
    check(32'(starts - n), 32'(e));
  endtask
  // Read data against oldest note; start and result counters
  always @(posedge clk_i) begin
    start_d <= start;
    if (start === 1'b1 && start_d !== 1'b1) starts++;
    if (strobe === 1'b1) nres++;
    if (rd && wreq === 1'b0 && expq.size() > 0) begin
      check(rdata, expq.pop_front());
    end
  end
  // Watchdog against a hang
  initial begin
    #400000;
    err_count++;
    results;
  end
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 8; i++) rdx(8'h70 + 8'(4 * i), 32'h0);
    rdx(8'h30, 32'h0);
    foreach (ofs[i]) begin
      d = $random(seed) & ~32'h1;
      bus(1'b1, ofs[i], d);
      rdx(ofs[i], d & msk[i]);
      bus(1'b1, ofs[i], 32'h0);
    end
    bus(1'b1, 8'h84, 32'hffffffff);
    bus(1'b1, 8'h90, 32'hffffffff);
    rdx(8'h84, 32'h0);
    rdx(8'h90, 32'h0);
    bus(1'b1, 8'h7c, 32'h08000100);
    bus(1'b1, 8'h80, 32'h01030007);
    bus(1'b1, 8'h78, 32'h7);
    bus(1'b1, 8'h70, 32'h1);
    conv(3'd0, 4'd5, 16'h0801);
    conv(3'd1, 4'd3, 16'h0800);
    conv(3'd2, 4'd7, 16'h00ff);
    conv(3'd3, 4'd2, 16'h0100);
    rdx(8'h74, 32'h0);
    rdx(8'h78, 32'h05070007);
    rdx(8'h84, 32'h00030007);
    rdx(8'h88, 32'h00030007);
    rdx(8'h30, 32'h80000801);
    rdx(8'h30, 32'h00000801);
    rdx(8'h34, 32'h80000800);
    conv(3'd2, 4'd9, 16'h0900);
    rdx(8'h84, 32'h01030007);
    rdx(8'h78, 32'h09070007);
    bus(1'b1, 8'h80, 32'h01000000);
    rdx(8'h88, 32'h01000000);
    bus(1'b1, 8'h8c, 32'h00030000);
    rdx(8'h84, 32'h01000007);
    bus(1'b1, 8'h8c, 32'h01000007);
    rdx(8'h84, 32'h0);
    bus(1'b1, 8'h78, 32'h402);
    conv(3'd4, 4'd5, 16'h0fff);
    conv(3'd5, 4'd4, 16'h000f);
    conv(3'd6, 4'd4, 16'h0fff);
    rdx(8'h78, 32'h04070402);
    rdx(8'h84, 32'h00020007);
    bus(1'b1, 8'h70, 32'h2);
    bus(1'b1, 8'h74, 32'h300);
    pulse(16'h0004, 30'h0, 0);
    pulse(16'h0008, 30'h0, 1);
    bus(1'b1, 8'h70, 32'h4);
    bus(1'b1, 8'h74, 32'h01020000);
    pulse(16'h0008, 30'h4000000, 0);
    pulse(16'h0, 30'h0200000, 1);
    bus(1'b1, 8'h70, 32'h8);
    bus(1'b1, 8'h74, 32'h20480000);
    pulse(16'h0, 30'h0000200, 0);
    pulse(16'h0, 30'h0000010, 1);
    pulse(16'h0, 30'h0200000, 0);
    bus(1'b1, 8'h70, 32'h0);
    pulse(16'hffff, 30'h3fffffff, 0);
    repeat (4) @(posedge clk_i);
    check(32'(expq.size()), 32'h0);
    results;
  end
endmodule
`default_nettype wire
